// [core/pcg_ctrl.sv]
// pll clock generator control: registers, protections, lock events, low power
// ----------------------------------------------------------------
// Function
// - codes zero and one multiply by one
// - multiplier writes ignored while pll on
// - range writes ignored while pll on
// - range zero disables pll, clears base select
// - range field resets to six
// - base select refused while range zero
// - auto mode: settled toggle raises event
// - flag always set; irq needs enable
// - manual mode: no irq, flag reads zero
// - base select ignores lock status
// - generator keeps running in wait mode
// - stop holds clock, irq and pll enable outputs low
// - stop clears base select, stays clear
// - break with clear enable allows clearing
// - break without clear enable protects flag
// - tracking bit follows analog tracking status in auto mode, manual bit otherwise
// - settled bit follows analog lock status in auto mode, reads zero otherwise
// - control register read clears flag
// - base select needs pll on, vice versa
// - multiplier field resets to six
// ----------------------------------------------------------------
`timescale 1ns/1ps
module pcg_ctrl (
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_b_i,
	input  wire logic [pcg_pkg::ADDR_W-1:0]    avs_address_i,
	input  wire logic                          avs_read_i,
	input  wire logic                          avs_write_i,
	input  wire logic [pcg_pkg::DATA_W-1:0]    avs_writedata_i,
	input  wire logic [pcg_pkg::DATA_W/8-1:0]  avs_byteenable_i,
	output logic      [pcg_pkg::DATA_W-1:0]    avs_readdata_o,
	output logic                               avs_waitrequest_o,
	input  wire logic                          crystal_clock_i,
	input  wire logic                          vco_clock_i,
	input  wire logic                          settled_i,
	input  wire logic                          tracking_i,
	input  wire logic                          stop_i,
	input  wire logic                          break_i,
	output logic                               crystal_clock_o,
	output logic                               base_clock_out_o,
	output logic                               pll_interrupt_o,
	output logic                               pll_enable_o,
	output logic      [pcg_pkg::FIELD_W-1:0]   multiplier_o,
	output logic      [pcg_pkg::FIELD_W-1:0]   vco_range_o,
	output logic                               clock_switching_o
);
	import pcg_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync3_reg;
	logic [SYNC_W-1:0] filt_reg;
	logic [SYNC_W-1:0] filt_next;
	logic [SYNC_W-1:0] agree;
	logic [SYNC_W-1:0] rise;
	logic [SYNC_W-1:0] pins;

	assign pins = {vco_clock_i, crystal_clock_i, tracking_i, settled_i};

	// a change counts only once stages two and three agree
	assign agree     = ~(sync2_reg ^ sync3_reg);
	assign filt_next = (sync2_reg & agree) | (filt_reg & ~agree);
	assign rise      = filt_next & ~filt_reg;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			sync1_reg <= SYNC_ZERO;
			sync2_reg <= SYNC_ZERO;
			sync3_reg <= SYNC_ZERO;
			filt_reg  <= SYNC_ZERO;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg  <= filt_next;
		end
	end

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic              ack_reg;
	logic [DATA_W-1:0] readdata_reg;
	logic [REG_W-1:0]  rd_byte;

	wire              bus_req  = avs_read_i | avs_write_i;
	wire              first    = bus_req & ~ack_reg;
	wire              acc_rd   = avs_read_i & ack_reg;
	wire              acc_wr   = avs_write_i & ack_reg & avs_byteenable_i[0];
	wire              hit_ctrl = (avs_address_i == CTRL_OFS);
	wire              hit_bw   = (avs_address_i == BW_OFS);
	wire              hit_prog = (avs_address_i == PROG_OFS);
	wire              hit_brk  = (avs_address_i == BRK_OFS);
	wire [REG_W-1:0]  wd       = avs_writedata_i[REG_W-1:0];

	// one wait cycle per access; data are captured in that cycle
	assign avs_waitrequest_o = first;
	assign avs_readdata_o    = readdata_reg;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ack_reg      <= 1'b0;
			readdata_reg <= widen(BYTE_ZERO);
		end else begin
			ack_reg <= first;
			if (first && avs_read_i) begin
				readdata_reg <= widen(rd_byte);
			end
		end
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	pcg_ctrl_s          ctrl_reg;
	pcg_ctrl_s          ctrl_next;
	pcg_prog_s          prog_reg;
	pcg_prog_s          prog_next;
	logic               auto_reg;
	logic               auto_next;
	logic               acq_man_reg;
	logic               acq_man_next;
	logic               break_clear_enable_reg;
	logic               break_clear_enable_next;

	wire wr_ctrl   = acc_wr & hit_ctrl;
	wire wr_bw     = acc_wr & hit_bw;
	wire wr_prog   = acc_wr & hit_prog & ~ctrl_reg.on;
	wire wr_brk    = acc_wr & hit_brk;
	wire vrs_zero  = (prog_reg.vrs == VRS_OFF);
	wire settled_s = filt_reg[SYN_SETTLED];
	wire track_s   = filt_reg[SYN_TRACK];

	// lock change is watched only in automatic mode
	wire lock_evt  = auto_reg & (filt_next[SYN_SETTLED] ^ settled_s);

	// read clears the flag unless break protection is in force
	wire flag_prot = break_i & ~break_clear_enable_reg;
	wire flag_clr  = acc_rd & hit_ctrl & ~flag_prot;

	// setting needs pll on and a nonzero range; lock state is not looked at
	wire bcs_ok    = ctrl_reg.on & ~vrs_zero;
	wire bcs_wr    = wr_ctrl ? (wd[CTRL_BCS_BIT] & (ctrl_reg.base_clock_select | bcs_ok)) : ctrl_reg.base_clock_select;

	assign ctrl_next.base_clock_select    = bcs_wr & ~vrs_zero & ~stop_i;
	assign ctrl_next.on     = wr_ctrl ? (wd[CTRL_ON_BIT] | ctrl_reg.base_clock_select) : ctrl_reg.on;
	assign ctrl_next.irq_en = (wr_ctrl & auto_reg) ? wd[CTRL_IE_BIT] : ctrl_reg.irq_en;
	// a new event in the clearing cycle wins
	assign ctrl_next.flag   = lock_evt | (ctrl_reg.flag & ~flag_clr);

	assign prog_next.mul  = wr_prog ? wd[PROG_MUL_LSB +: FIELD_W] : prog_reg.mul;
	assign prog_next.vrs  = wr_prog ? wd[PROG_VRS_LSB +: FIELD_W] : prog_reg.vrs;

	// the manual acquisition bit is kept while automatic mode owns it
	assign auto_next    = wr_bw ? wd[BW_AUTO_BIT] : auto_reg;
	assign acq_man_next = (wr_bw & ~auto_reg) ? wd[BW_ACQ_BIT] : acq_man_reg;
	assign break_clear_enable_next    = wr_brk ? wd[BRK_BREAK_CLEAR_ENABLE_BIT] : break_clear_enable_reg;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ctrl_reg.irq_en <= 1'b0;
			ctrl_reg.flag   <= 1'b0;
			ctrl_reg.on     <= ON_RESET;
			ctrl_reg.base_clock_select    <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			prog_reg.mul <= MUL_RESET;
			prog_reg.vrs <= VRS_RESET;
		end else begin
			prog_reg <= prog_next;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			auto_reg    <= 1'b0;
			acq_man_reg <= 1'b0;
			break_clear_enable_reg    <= 1'b0;
		end else begin
			auto_reg    <= auto_next;
			acq_man_reg <= acq_man_next;
			break_clear_enable_reg    <= break_clear_enable_next;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [REG_W-1:0] ctrl_rd;
	logic [REG_W-1:0] bw_rd;
	logic [REG_W-1:0] prog_rd;
	logic [REG_W-1:0] brk_rd;

	always_comb begin
		ctrl_rd                = CTRL_UNUSED_ONES;
		ctrl_rd[CTRL_IE_BIT]   = ctrl_reg.irq_en & auto_reg;
		ctrl_rd[CTRL_FLAG_BIT] = ctrl_reg.flag & auto_reg;
		ctrl_rd[CTRL_ON_BIT]   = ctrl_reg.on;
		ctrl_rd[CTRL_BCS_BIT]  = ctrl_reg.base_clock_select;
		bw_rd                  = BYTE_ZERO;
		bw_rd[BW_AUTO_BIT]     = auto_reg;
		bw_rd[BW_LOCK_BIT]     = auto_reg & settled_s;
		bw_rd[BW_ACQ_BIT]      = auto_reg ? track_s : acq_man_reg;
		prog_rd                = {prog_reg.mul, prog_reg.vrs};
		brk_rd                 = BYTE_ZERO;
		brk_rd[BRK_BREAK_CLEAR_ENABLE_BIT]   = break_clear_enable_reg;
	end

	// unmapped offsets read as zero
	assign rd_byte = hit_ctrl ? ctrl_rd :
	                 hit_bw   ? bw_rd   :
	                 hit_prog ? prog_rd :
	                 hit_brk  ? brk_rd  : BYTE_ZERO;

	// ----------------------------------------------------------------
	// outputs to the analog loop and the system
	// ----------------------------------------------------------------
	logic                pll_en_reg;
	logic [FIELD_W-1:0]  mult_reg;
	logic [FIELD_W-1:0]  range_reg;
	logic                irq_reg;
	logic                xtal_out_reg;

	// wait mode has no input here: the generator simply keeps running
	wire pll_en_next = ctrl_reg.on & ~vrs_zero & ~stop_i;
	wire irq_next    = ctrl_reg.flag & ctrl_reg.irq_en & auto_reg & ~stop_i;
	wire xtal_next   = filt_reg[SYN_XTAL] & ~stop_i;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pll_en_reg   <= 1'b0;
			mult_reg     <= MUL_ONE;
			range_reg    <= VRS_OFF;
			irq_reg      <= 1'b0;
			xtal_out_reg <= 1'b0;
		end else begin
			pll_en_reg   <= pll_en_next;
			mult_reg     <= mul_decode(prog_reg.mul);
			range_reg    <= prog_reg.vrs;
			irq_reg      <= irq_next;
			xtal_out_reg <= xtal_next;
		end
	end

	assign pll_enable_o    = pll_en_reg;
	assign multiplier_o    = mult_reg;
	assign vco_range_o     = range_reg;
	assign pll_interrupt_o = irq_reg;
	assign crystal_clock_o = xtal_out_reg;

	// ----------------------------------------------------------------
	// base clock selector
	// ----------------------------------------------------------------
	// sampled sources limit the output to well under a quarter of the bus clock
	pcg_clk_sel u_clk_sel (
		.core_clk_i       (core_clk_i),
		.rst_b_i          (rst_b_i),
		.xtal_rise_i      (rise[SYN_XTAL]),
		.vco_rise_i       (rise[SYN_VCO]),
		.sel_vco_i        (ctrl_reg.base_clock_select),
		.stop_i           (stop_i),
		.base_clock_out_o (base_clock_out_o),
		.switching_o      (clock_switching_o)
	);

endmodule

// [core/pcg_pkg.sv]
// constants, field layouts and types shared by the pll clock generator control
package pcg_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W  = 8;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] BW_OFS   = 4'h4;
	localparam logic [ADDR_W-1:0] PROG_OFS = 4'h8;
	localparam logic [ADDR_W-1:0] BRK_OFS  = 4'hC;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_IE_BIT   = 7;
	localparam int unsigned CTRL_FLAG_BIT = 6;
	localparam int unsigned CTRL_ON_BIT   = 5;
	localparam int unsigned CTRL_BCS_BIT  = 4;
	localparam int unsigned BW_AUTO_BIT   = 7;
	localparam int unsigned BW_LOCK_BIT   = 6;
	localparam int unsigned BW_ACQ_BIT    = 5;
	localparam int unsigned BRK_BREAK_CLEAR_ENABLE_BIT  = 7;
	localparam int unsigned PROG_MUL_LSB  = 4;
	localparam int unsigned PROG_VRS_LSB  = 0;
	localparam int unsigned FIELD_W       = 4;

	// ----------------------------------------------------------------
	// reset and fixed values
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0]   CTRL_UNUSED_ONES = 8'h0F;
	localparam logic [REG_W-1:0]   BYTE_ZERO        = 8'h00;
	localparam logic [DATA_W-REG_W-1:0] UPPER_ZERO  = 24'h00_0000;
	localparam logic [FIELD_W-1:0] MUL_RESET        = 4'h6;
	localparam logic [FIELD_W-1:0] VRS_RESET        = 4'h6;
	localparam logic [FIELD_W-1:0] MUL_ONE          = 4'h1;
	localparam logic [FIELD_W-1:0] MUL_ZERO         = 4'h0;
	localparam logic [FIELD_W-1:0] VRS_OFF          = 4'h0;
	localparam logic               ON_RESET         = 1'b1;

	// ----------------------------------------------------------------
	// clock switch timing: source edges waited on each side
	// ----------------------------------------------------------------
	localparam int unsigned  SW_CNT_W    = 2;
	localparam logic [SW_CNT_W-1:0] SW_EDGES = 2'h3;
	localparam logic [SW_CNT_W-1:0] SW_ZERO  = 2'h0;
	localparam logic [SW_CNT_W-1:0] SW_ONE   = 2'h1;

	// ----------------------------------------------------------------
	// pin synchroniser lanes
	// ----------------------------------------------------------------
	localparam int unsigned SYNC_W      = 4;
	localparam int unsigned SYN_SETTLED = 0;
	localparam int unsigned SYN_TRACK   = 1;
	localparam int unsigned SYN_XTAL    = 2;
	localparam int unsigned SYN_VCO     = 3;
	localparam logic [SYNC_W-1:0] SYNC_ZERO = 4'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic irq_en;
		logic flag;
		logic on;
		logic base_clock_select;
	} pcg_ctrl_s;

	typedef struct packed {
		logic [FIELD_W-1:0] mul;
		logic [FIELD_W-1:0] vrs;
	} pcg_prog_s;

	typedef enum logic [1:0] {
		SEL_RUN,
		SEL_DRAIN_OLD,
		SEL_WAIT_NEW
	} pcg_sel_e;

	// multiplier code to vco multiplier
	function automatic logic [FIELD_W-1:0] mul_decode(input logic [FIELD_W-1:0] code);
		mul_decode = (code == MUL_ZERO) ? MUL_ONE : code;
	endfunction

	// register byte read onto the bus word
	function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] b);
		widen = {UPPER_ZERO, b};
	endfunction

endpackage

// [core/pcg_clk_sel.sv]
// glitch-free base clock selector with divide-by-two output
`timescale 1ns/1ps
module pcg_clk_sel (
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	input  wire logic xtal_rise_i,
	input  wire logic vco_rise_i,
	input  wire logic sel_vco_i,
	input  wire logic stop_i,
	output logic      base_clock_out_o,
	output logic      switching_o
);
	import pcg_pkg::*;

	pcg_sel_e            state_reg;
	pcg_sel_e            state_next;
	logic                cur_reg;
	logic                cur_next;
	logic                tgt_reg;
	logic                tgt_next;
	logic [SW_CNT_W-1:0] cnt_reg;
	logic [SW_CNT_W-1:0] cnt_next;
	logic                out_reg;
	logic                out_next;

	wire old_rise = cur_reg ? vco_rise_i : xtal_rise_i;
	wire new_rise = tgt_reg ? vco_rise_i : xtal_rise_i;

	// ----------------------------------------------------------------
	// selector sequence
	// ----------------------------------------------------------------
	// output frozen until both sources showed three edges
	always_comb begin
		state_next = state_reg;
		cur_next   = cur_reg;
		tgt_next   = tgt_reg;
		cnt_next   = cnt_reg;
		out_next   = out_reg;
		unique case (state_reg)
			SEL_RUN: begin
				if (sel_vco_i != cur_reg) begin
					state_next = SEL_DRAIN_OLD;
					tgt_next   = sel_vco_i;
					cnt_next   = SW_ZERO;
				end else if (old_rise) begin
					out_next = ~out_reg;
				end
			end
			SEL_DRAIN_OLD: begin
				if (old_rise) begin
					cnt_next = cnt_reg + SW_ONE;
					if (cnt_reg + SW_ONE == SW_EDGES) begin
						state_next = SEL_WAIT_NEW;
						cnt_next   = SW_ZERO;
					end
				end
			end
			SEL_WAIT_NEW: begin
				if (new_rise) begin
					cnt_next = cnt_reg + SW_ONE;
					if (cnt_reg + SW_ONE == SW_EDGES) begin
						state_next = SEL_RUN;
						cur_next   = tgt_reg;
					end
				end
			end
		endcase
		// crystal edges stop in stop mode, so a pending switch is dropped
		if (stop_i) begin
			state_next = SEL_RUN;
			cur_next   = 1'b0;
			out_next   = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_reg <= SEL_RUN;
			cur_reg   <= 1'b0;
			tgt_reg   <= 1'b0;
			cnt_reg   <= SW_ZERO;
			out_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			cur_reg   <= cur_next;
			tgt_reg   <= tgt_next;
			cnt_reg   <= cnt_next;
			out_reg   <= out_next;
		end
	end

	assign base_clock_out_o = out_reg;
	assign switching_o      = (state_reg != SEL_RUN);

endmodule

// [tb/pcg_ctrl_chk.sv]
// concurrent checks on the ports of the pll clock generator control
`timescale 1ns/1ps
module pcg_ctrl_chk (
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_b_i,
	input  wire logic [pcg_pkg::ADDR_W-1:0]   avs_address_i,
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [pcg_pkg::DATA_W-1:0]   avs_writedata_i,
	input  wire logic [pcg_pkg::DATA_W/8-1:0] avs_byteenable_i,
	input  wire logic [pcg_pkg::DATA_W-1:0]   avs_readdata_o,
	input  wire logic                         avs_waitrequest_o,
	input  wire logic                         settled_i,
	input  wire logic                         stop_i,
	input  wire logic                         break_i,
	input  wire logic                         crystal_clock_o,
	input  wire logic                         base_clock_out_o,
	input  wire logic                         pll_interrupt_o,
	input  wire logic                         pll_enable_o,
	input  wire logic [pcg_pkg::FIELD_W-1:0]  multiplier_o,
	input  wire logic [pcg_pkg::FIELD_W-1:0]  vco_range_o,
	input  wire logic                         clock_switching_o
);
	import pcg_pkg::*;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic acc      = !avs_waitrequest_o && (avs_read_i || avs_write_i);
	wire logic acc_prog = acc && avs_write_i && avs_address_i == PROG_OFS && avs_byteenable_i[0];
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	// settled held still so a new lock event cannot win over the clear
	sequence s_ctrl_rd;
		acc && avs_read_i && avs_address_i == CTRL_OFS && !break_i && settled_i == $past(settled_i, 6);
	endsequence
	sequence s_manual_wr;
		acc && avs_write_i && avs_address_i == BW_OFS && avs_byteenable_i[0] && !avs_writedata_i[BW_AUTO_BIT];
	endsequence
	property p_wait;      s_req |=> !avs_waitrequest_o; endproperty
	property p_mul_nz;    multiplier_o != MUL_ZERO; endproperty
	property p_range_off; vco_range_o == VRS_OFF |-> !pll_enable_o; endproperty
	property p_stop;
		stop_i [*2] |-> !crystal_clock_o && !base_clock_out_o && !pll_interrupt_o && !pll_enable_o;
	endproperty
	property p_switch;    (clock_switching_o && !stop_i) [*2] |-> $stable(base_clock_out_o); endproperty
	property p_rd_clr;    s_ctrl_rd |=> ##1 !pll_interrupt_o; endproperty
	property p_manual;    s_manual_wr |=> ##1 !pll_interrupt_o; endproperty
	property p_mul_hold;
		!$stable(multiplier_o) |-> $past(acc_prog, 1) || $past(acc_prog, 2) || !$past(rst_b_i, 2);
	endproperty
	property p_upper;     avs_readdata_o[DATA_W-1:REG_W] == UPPER_ZERO; endproperty
	a_wait:      assert property (p_wait) else $error("waitrequest held past one cycle");
	a_mul_nz:    assert property (p_mul_nz) else $error("multiplier decoded to zero");
	a_range_off: assert property (p_range_off) else $error("pll enabled with range zero");
	a_stop:      assert property (p_stop) else $error("output active in stop");
	a_switch:    assert property (p_switch) else $error("base clock moved during switch");
	a_rd_clr:    assert property (p_rd_clr) else $error("interrupt kept after control read");
	a_manual:    assert property (p_manual) else $error("interrupt in manual mode");
	a_mul_hold:  assert property (p_mul_hold) else $error("multiplier changed without write");
	a_upper:     assert property (p_upper) else $error("read data upper bits set");
endmodule

// [tb/testbench.sv]
// self-checking bench for the pll clock generator control
`timescale 1ns/1ps
module testbench;
	import pcg_pkg::*;
	logic                core_clk_i = 1'b0;
	logic                rst_b_i = 1'b0;
	logic [ADDR_W-1:0]   avs_address_i = 4'h0;
	logic                avs_read_i = 1'b0;
	logic                avs_write_i = 1'b0;
	logic [DATA_W-1:0]   avs_writedata_i = 32'h0000_0000;
	logic [DATA_W/8-1:0] avs_byteenable_i = 4'hF;
	logic [DATA_W-1:0]   avs_readdata_o;
	logic                avs_waitrequest_o;
	logic                crystal_clock_i = 1'b0;
	logic                vco_clock_i = 1'b0;
	logic                settled_i = 1'b0;
	logic                tracking_i = 1'b0;
	logic                stop_i = 1'b0;
	logic                break_i = 1'b0;
	logic                crystal_clock_o;
	logic                base_clock_out_o;
	logic                pll_interrupt_o;
	logic                pll_enable_o;
	logic [FIELD_W-1:0]  multiplier_o;
	logic [FIELD_W-1:0]  vco_range_o;
	logic                clock_switching_o;
	logic [2:0]          xcnt = 3'h0;
	logic [2:0]          vcnt = 3'h0;
	int                  fail_count = 0;
	int                  checks = 0;
	pcg_ctrl DUT (.core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .crystal_clock_i, .vco_clock_i, .settled_i,
		.tracking_i, .stop_i, .break_i, .crystal_clock_o, .base_clock_out_o, .pll_interrupt_o, .pll_enable_o,
		.multiplier_o, .vco_range_o, .clock_switching_o);
	always #12.5 core_clk_i = ~core_clk_i;
	// source clocks slow enough for the pin synchronisers to see every level
	always @(posedge core_clk_i) begin
		xcnt <= xcnt + 3'h1;
		vcnt <= (vcnt == 3'h5) ? 3'h0 : vcnt + 3'h1;
		crystal_clock_i <= xcnt[2];
		vco_clock_i <= (vcnt < 3'h3);
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	// waitrequest and read data are taken as they stand just before each rising edge
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
		output logic [DATA_W-1:0] q);
		int n;
		n = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {UPPER_ZERO, d};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		chk("bus answer", n < 20, 1'b1);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		logic [DATA_W-1:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
		logic [DATA_W-1:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, q, {UPPER_ZERO, e});
	endtask
	task automatic drv(input logic s, input logic t, input logic b);
		@(posedge core_clk_i);
		settled_i <= s;
		tracking_i <= t;
		break_i <= b;
		cyc(8);
	endtask
	task automatic wait_sw;
		int n;
		n = 0;
		while (clock_switching_o !== 1'b1 && n < 50) begin
			n++;
			cyc(1);
		end
		while (clock_switching_o !== 1'b0 && n < 400) begin
			n++;
			cyc(1);
		end
		chk("switch done", clock_switching_o, 1'b0);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("mul out", multiplier_o, 4'h6);
		chk("range out", vco_range_o, 4'h6);
		rd("ctrl", CTRL_OFS, 8'h2F);
		rd("bw", BW_OFS, 8'h00);
		rd("prog", PROG_OFS, 8'h66);
		rd("brk", BRK_OFS, 8'h00);
		rd("unmapped", 4'h2, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_prog;
		wr(PROG_OFS, 8'h35);
		rd("prog locked", PROG_OFS, 8'h66);
		wr(CTRL_OFS, 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(PROG_OFS, {i[3:0], 4'h6});
			cyc(2);
			chk("mul decode", multiplier_o, (i < 2) ? 4'h1 : i[3:0]);
		end
		wr(PROG_OFS, 8'h60);
		wr(CTRL_OFS, 8'h20);
		wr(CTRL_OFS, 8'h30);
		rd("bcs range zero", CTRL_OFS, 8'h2F);
		cyc(2);
		chk("enable range zero", pll_enable_o, 1'b0);
		wr(CTRL_OFS, 8'h00);
		wr(PROG_OFS, 8'h66);
		wr(CTRL_OFS, 8'h10);
		rd("bcs pll off", CTRL_OFS, 8'h0F);
		$display("programming test done");
	endtask
	task automatic t_switch;
		int n;
		logic prev;
		n = 0;
		wr(CTRL_OFS, 8'h20);
		cyc(2);
		chk("enable", pll_enable_o, 1'b1);
		wr(CTRL_OFS, 8'h30);
		rd("bcs unlocked", CTRL_OFS, 8'h3F);
		wait_sw();
		wr(CTRL_OFS, 8'h00);
		rd("on kept", CTRL_OFS, 8'h2F);
		wait_sw();
		prev = base_clock_out_o;
		repeat (64) begin
			cyc(1);
			n += (base_clock_out_o !== prev) ? 1 : 0;
			prev = base_clock_out_o;
		end
		chk("base running", n > 4, 1'b1);
		$display("switch test done");
	endtask
	task automatic t_irq;
		wr(BW_OFS, 8'h80);
		wr(CTRL_OFS, 8'hA0);
		drv(1'b1, 1'b0, 1'b0);
		chk("irq lock", pll_interrupt_o, 1'b1);
		rd("settled", BW_OFS, 8'hC0);
		drv(1'b1, 1'b1, 1'b0);
		rd("tracking", BW_OFS, 8'hE0);
		rd("flag set", CTRL_OFS, 8'hEF);
		cyc(3);
		chk("irq cleared", pll_interrupt_o, 1'b0);
		rd("flag cleared", CTRL_OFS, 8'hAF);
		wr(CTRL_OFS, 8'h20);
		drv(1'b0, 1'b1, 1'b0);
		chk("irq masked", pll_interrupt_o, 1'b0);
		rd("flag unlock", CTRL_OFS, 8'h6F);
		drv(1'b1, 1'b1, 1'b0);
		wr(BW_OFS, 8'h00);
		cyc(3);
		rd("flag manual", CTRL_OFS, 8'h2F);
		chk("irq manual", pll_interrupt_o, 1'b0);
		$display("interrupt test done");
	endtask
	task automatic t_brk;
		logic [DATA_W-1:0] q;
		wr(BW_OFS, 8'h80);
		bus(1'b0, CTRL_OFS, 8'h00, q);
		drv(1'b0, 1'b1, 1'b1);
		rd("brk flag 1", CTRL_OFS, 8'h6F);
		wr(CTRL_OFS, 8'h20);
		rd("brk flag 2", CTRL_OFS, 8'h6F);
		wr(BRK_OFS, 8'h80);
		rd("brk clear", CTRL_OFS, 8'h6F);
		drv(1'b0, 1'b1, 1'b0);
		rd("stays clear", CTRL_OFS, 8'h2F);
		$display("break test done");
	endtask
	task automatic t_stop;
		drv(1'b1, 1'b1, 1'b0);
		rd("settled first", BW_OFS, 8'hE0);
		wr(CTRL_OFS, 8'h30);
		wait_sw();
		@(posedge core_clk_i);
		stop_i <= 1'b1;
		cyc(4);
		chk("xtal stop", crystal_clock_o, 1'b0);
		chk("base stop", base_clock_out_o, 1'b0);
		chk("irq stop", pll_interrupt_o, 1'b0);
		rd("bcs stop", CTRL_OFS, 8'h6F);
		@(posedge core_clk_i);
		stop_i <= 1'b0;
		cyc(20);
		rd("bcs after", CTRL_OFS, 8'h2F);
		$display("stop test done");
	endtask
	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		cyc(2);
		t_reset();
		t_prog();
		t_switch();
		t_irq();
		t_brk();
		t_stop();
		finish_test();
	end
endmodule
bind pcg_ctrl pcg_ctrl_chk u_chk (.core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .settled_i, .stop_i, .break_i,
	.crystal_clock_o, .base_clock_out_o, .pll_interrupt_o, .pll_enable_o, .multiplier_o, .vco_range_o,
	.clock_switching_o);
